/* ipsel_pkg.sv */
// Package of constants for the interrupt priority select block
package ipsel_pkg;
  // ***************************************************
  // Register map and fields
  // ***************************************************
  localparam logic [7:0] IPSEL_PRIO_ADDR = 8'hb8;
  localparam logic [7:0] IPSEL_PRIO_RESET = 8'h80;
  localparam logic [7:0] IPSEL_PRIO_WMASK = 8'h7f;
  localparam int IPSEL_BIT_RSVD = 7;
  localparam int IPSEL_BIT_SPI = 6;
  localparam int IPSEL_BIT_T2 = 5;
  localparam int IPSEL_BIT_UART = 4;
  localparam int IPSEL_BIT_T1 = 3;
  localparam int IPSEL_BIT_EX1 = 2;
  localparam int IPSEL_BIT_T0 = 1;
  localparam int IPSEL_BIT_EX0 = 0;
  localparam int IPSEL_NSRC = 7;
  // Bit-addressable SFR bit addresses: base 0xb8 plus bit number
  localparam logic [4:0] IPSEL_BITADDR_BASE = 5'h17;
  localparam logic [2:0] IPSEL_NO_SRC = 3'h7;
endpackage

/* ipsel_arbiter.sv */
// Priority arbiter that picks one pending source by level and index
`timescale 1ns/100ps
module ipsel_arbiter
  import ipsel_pkg::*;
(
  input wire logic [6:0] pending_in,
  input wire logic [6:0] high_level_in,
  input wire logic [1:0] active_levels_in,
  output logic grant_valid_out,
  output logic [2:0] grant_index_out,
  output logic grant_high_out
);
  // Lowest index wins within a level, as in the fixed polling order
  function automatic logic [2:0] ipsel_first(input logic [6:0] req);
    logic [2:0] idx;
    idx = IPSEL_NO_SRC;
    for (int i = IPSEL_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [6:0] high_req;
  logic [6:0] low_req;
  logic high_ok;
  logic low_ok;

  always_comb begin
    high_req = pending_in & high_level_in;
    low_req = pending_in & ~high_level_in;
    // High preempts low but nothing preempts a high service
    high_ok = (|high_req) && !active_levels_in[1]; // [RULE_11]
    low_ok = (|low_req) && (active_levels_in == 2'b00);
    grant_valid_out = high_ok || low_ok;
    grant_high_out = high_ok;
    if (high_ok) begin
      grant_index_out = ipsel_first(high_req); // [RULE_11]
    end else if (low_ok) begin
      grant_index_out = ipsel_first(low_req);
    end else begin
      grant_index_out = IPSEL_NO_SRC;
    end
  end
endmodule

/* ipsel_top.sv */
// Interrupt priority select register with its level arbitration
`timescale 1ns/100ps
// What this block does
// RULE_01 - The priority register is eight bits at SFR address 0xb8 and takes byte and single-bit accesses.
// RULE_02 - Software keeps bit 7 at one when writing; the block makes it read-only.
// RULE_03 - Bit 6 gives the SPI interrupt low level when clear and high level when set.
// RULE_04 - Bit 5 gives the second timer interrupt low level when clear and high level when set.
// RULE_05 - Bit 4 gives the UART interrupt low level when clear and high level when set.
// RULE_06 - Bit 3 gives the timer one interrupt low level when clear and high level when set.
// RULE_07 - Bit 2 gives external interrupt one low level when clear and high level when set.
// RULE_08 - Bit 1 gives the timer zero interrupt low level when clear and high level when set.
// RULE_09 - Bit 0 gives external interrupt zero low level when clear and high level when set.
// RULE_10 - After reset all seven level bits read zero and bit 7 reads one.
// RULE_11 - A pending high-level request is served before low ones and may preempt a low-level service.
module ipsel_top
  import ipsel_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic bit_wr_in,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_wdata_in,
  input wire logic [6:0] pending_in,
  input wire logic irq_ack_in,
  input wire logic reti_in,
  output logic [7:0] sfr_rdata_out,
  output logic bit_rdata_out,
  output logic spi_irq_high_level_out,
  output logic timer_two_irq_high_level_out,
  output logic uart_irq_high_level_out,
  output logic timer_one_irq_high_level_out,
  output logic ext_irq_one_high_level_out,
  output logic timer_zero_irq_high_level_out,
  output logic ext_irq_zero_high_level_out,
  output logic grant_valid_out,
  output logic [2:0] grant_index_out,
  output logic grant_high_out
);
  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [7:0] interrupt_priority_levels;
    logic [1:0] active_levels;
  } ipsel_state_s;

  ipsel_state_s state;
  ipsel_state_s next_state;
  logic byte_hit;
  logic bit_hit;
  logic [2:0] bit_sel;
  logic arb_valid;
  logic arb_high;
  logic [2:0] arb_index;

  // ***************************************************
  // Decode and register update
  // ***************************************************
  always_comb begin
    next_state = state;
    byte_hit = (sfr_addr_in == IPSEL_PRIO_ADDR); // [RULE_01]
    bit_hit = (bit_addr_in[7:3] == IPSEL_BITADDR_BASE); // [RULE_01]
    bit_sel = bit_addr_in[2:0];
    if (sfr_wr_in && byte_hit) begin
      // Bit 7 is forced high whatever software writes
      next_state.interrupt_priority_levels = (sfr_wdata_in & IPSEL_PRIO_WMASK) | IPSEL_PRIO_RESET; // [RULE_02]
    end else if (bit_wr_in && bit_hit && (bit_sel != 3'(IPSEL_BIT_RSVD))) begin
      next_state.interrupt_priority_levels[bit_sel] = bit_wdata_in; // [RULE_01] [RULE_02]
    end
    // Level stack: a return pops the top level first and an ack then pushes the granted one,
    // so an ack in the same cycle as a return is never lost
    if (reti_in) begin
      if (state.active_levels[1]) begin
        next_state.active_levels[1] = 1'b0;
      end else begin
        next_state.active_levels[0] = 1'b0;
      end
    end
    if (irq_ack_in && arb_valid) begin
      if (arb_high) begin
        next_state.active_levels[1] = 1'b1; // [RULE_11]
      end else begin
        next_state.active_levels[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state.interrupt_priority_levels <= IPSEL_PRIO_RESET; // [RULE_10]
      state.active_levels <= 2'b00;
    end else begin
      state <= next_state;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign sfr_rdata_out = state.interrupt_priority_levels;
  assign bit_rdata_out = state.interrupt_priority_levels[bit_sel];
  assign spi_irq_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_SPI]; // [RULE_03]
  assign timer_two_irq_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_T2]; // [RULE_04]
  assign uart_irq_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_UART]; // [RULE_05]
  assign timer_one_irq_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_T1]; // [RULE_06]
  assign ext_irq_one_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_EX1]; // [RULE_07]
  assign timer_zero_irq_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_T0]; // [RULE_08]
  assign ext_irq_zero_high_level_out = state.interrupt_priority_levels[IPSEL_BIT_EX0]; // [RULE_09]

  ipsel_arbiter u_arb (
    .pending_in(pending_in),
    .high_level_in(state.interrupt_priority_levels[6:0]),
    .active_levels_in(state.active_levels),
    .grant_valid_out(arb_valid),
    .grant_index_out(arb_index),
    .grant_high_out(arb_high)
  );
  assign grant_valid_out = arb_valid;
  assign grant_index_out = arb_index;
  assign grant_high_out = arb_high;

  // ***************************************************
  // Assertions
  // ***************************************************
  sequence seq_byte_write;
    sfr_wr_in && (sfr_addr_in == IPSEL_PRIO_ADDR);
  endsequence

  sequence seq_bit_write;
    bit_wr_in && bit_hit && (bit_sel != 3'(IPSEL_BIT_RSVD)) && !(sfr_wr_in && byte_hit);
  endsequence

  AST_RSVD_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in) sfr_rdata_out[7]) // [RULE_02]
    else $error("reserved bit not one");
  AST_RESET_VALUE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_10]
    $rose(reset_n_in) |-> (sfr_rdata_out == IPSEL_PRIO_RESET) && (state.active_levels == 2'b00))
    else $error("state after reset wrong");
  AST_BYTE_WRITE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_01]
    seq_byte_write |=> (sfr_rdata_out[6:0] == $past(sfr_wdata_in[6:0])))
    else $error("byte write not stored");
  AST_BIT_WRITE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_01]
    seq_bit_write |=> (sfr_rdata_out[$past(bit_sel)] == $past(bit_wdata_in)))
    else $error("bit write not stored");
  AST_BIT7_REFUSED: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_02]
    (bit_wr_in && bit_hit && (bit_sel == 3'(IPSEL_BIT_RSVD)) && !sfr_wr_in) |=> $stable(sfr_rdata_out))
    else $error("reserved bit write changed the register");
  AST_OTHER_ADDR: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_01]
    (sfr_wr_in && !byte_hit && !bit_wr_in) |=> $stable(sfr_rdata_out))
    else $error("write to another address changed the register");
  AST_BIT_OTHER: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_01]
    (bit_wr_in && !bit_hit && !sfr_wr_in) |=> $stable(sfr_rdata_out))
    else $error("bit write to another address changed the register");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_10]
    (!sfr_wr_in && !bit_wr_in) |=> $stable(sfr_rdata_out))
    else $error("register changed without write");

  // Each level output must follow its own register bit
  AST_SPI_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_03]
    spi_irq_high_level_out == sfr_rdata_out[IPSEL_BIT_SPI])
    else $error("spi level map wrong");
  AST_T2_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_04]
    timer_two_irq_high_level_out == sfr_rdata_out[IPSEL_BIT_T2])
    else $error("timer two level map wrong");
  AST_UART_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_05]
    uart_irq_high_level_out == sfr_rdata_out[IPSEL_BIT_UART])
    else $error("uart level map wrong");
  AST_T1_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_06]
    timer_one_irq_high_level_out == sfr_rdata_out[IPSEL_BIT_T1])
    else $error("timer one level map wrong");
  AST_EX1_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_07]
    ext_irq_one_high_level_out == sfr_rdata_out[IPSEL_BIT_EX1])
    else $error("external one level map wrong");
  AST_T0_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_08]
    timer_zero_irq_high_level_out == sfr_rdata_out[IPSEL_BIT_T0])
    else $error("timer zero level map wrong");
  AST_EX0_MAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_09]
    ext_irq_zero_high_level_out == sfr_rdata_out[IPSEL_BIT_EX0])
    else $error("external zero level map wrong");

  // ***************************************************
  // Arbitration and level stack assertions
  // ***************************************************
  sequence seq_take_high;
    irq_ack_in && grant_valid_out && grant_high_out;
  endsequence
  sequence seq_take_low;
    irq_ack_in && grant_valid_out && !grant_high_out;
  endsequence
  sequence seq_return_high;
    reti_in && !irq_ack_in && state.active_levels[1];
  endsequence
  sequence seq_return_low;
    reti_in && !irq_ack_in && !state.active_levels[1];
  endsequence

  AST_HIGH_FIRST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    (|(pending_in & state.interrupt_priority_levels[6:0]) && !state.active_levels[1]) |-> grant_high_out)
    else $error("high request not preferred");
  AST_NO_LOW_NEST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    (state.active_levels != 2'b00) |-> !(grant_valid_out && !grant_high_out))
    else $error("low request nested");
  AST_LOWEST_FIRST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    grant_high_out |-> ((pending_in & state.interrupt_priority_levels[6:0] & ~(7'h7f << grant_index_out)) == 7'h00))
    else $error("high grant skipped a lower index");
  AST_GRANT_PENDING: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    grant_valid_out |-> pending_in[grant_index_out])
    else $error("grant for a source not pending");
  AST_GRANT_IDLE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    !grant_valid_out |-> (grant_index_out == IPSEL_NO_SRC))
    else $error("idle grant index wrong");
  AST_PUSH_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    seq_take_high |=> state.active_levels[1])
    else $error("high level not pushed");
  AST_PUSH_LOW: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    seq_take_low |=> (state.active_levels == 2'b01))
    else $error("low level not pushed");
  AST_POP_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    seq_return_high |=> !state.active_levels[1] && (state.active_levels[0] == $past(state.active_levels[0])))
    else $error("high level not popped");
  AST_POP_LOW: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_11]
    seq_return_low |=> (state.active_levels == 2'b00))
    else $error("low level not popped");
endmodule

/* ipsel_cpu_model.sv */
// CPU core side that accepts a granted interrupt on request
`timescale 1ns/100ps
module ipsel_cpu_model (
  input wire logic clk_in,
  input wire logic take_in,
  input wire logic grant_valid_in,
  output logic irq_ack_out
);
  // Accept only a valid grant; the block itself ignores an ack that comes with no valid grant
  initial irq_ack_out = 1'b0;
  always @(posedge clk_in) begin
    irq_ack_out <= take_in && grant_valid_in;
  end
endmodule

/* test_interrupt_priority_select.sv */
// Self-checking bench for the interrupt priority select block
`timescale 1ns/100ps
module test_interrupt_priority_select;
  import ipsel_pkg::*;
  logic clk_in = 0, reset_n_in = 0, sfr_wr_in = 0, bit_wr_in = 0, bit_wdata_in = 0, reti_in = 0, take = 0;
  logic [7:0] sfr_addr_in = 8'hb8, sfr_wdata_in = 8'h80, bit_addr_in = 8'hb8, sfr_rdata_out;
  logic [6:0] pending_in = 7'h00;
  wire [6:0] lv;
  logic [2:0] grant_index_out;
  logic irq_ack_in, bit_rdata_out, grant_valid_out, grant_high_out;
  int err_total = 0, comparisons = 0;
  ipsel_top ipsel_top_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .bit_wr_in(bit_wr_in), .bit_addr_in(bit_addr_in),
    .bit_wdata_in(bit_wdata_in), .pending_in(pending_in), .irq_ack_in(irq_ack_in), .reti_in(reti_in),
    .sfr_rdata_out(sfr_rdata_out), .bit_rdata_out(bit_rdata_out), .spi_irq_high_level_out(lv[6]),
    .timer_two_irq_high_level_out(lv[5]), .uart_irq_high_level_out(lv[4]),
    .timer_one_irq_high_level_out(lv[3]), .ext_irq_one_high_level_out(lv[2]),
    .timer_zero_irq_high_level_out(lv[1]), .ext_irq_zero_high_level_out(lv[0]),
    .grant_valid_out(grant_valid_out), .grant_index_out(grant_index_out), .grant_high_out(grant_high_out));
  ipsel_cpu_model ipsel_cpu_model_inst (.clk_in(clk_in), .take_in(take), .grant_valid_in(grant_valid_out),
    .irq_ack_out(irq_ack_in));
  initial forever #25 clk_in = ~clk_in;
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Byte write through the SFR port, one strobe cycle
  task automatic byte_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in = a; sfr_wdata_in = d; sfr_wr_in = 1;
    @(negedge clk_in);
    sfr_wr_in = 0;
  endtask
  task automatic bit_wr(input logic [7:0] a, input logic v);
    @(negedge clk_in);
    bit_addr_in = a; bit_wdata_in = v; bit_wr_in = 1;
    @(negedge clk_in);
    bit_wr_in = 0;
  endtask
  task automatic t_reset();
    chk("reset_reg", IPSEL_PRIO_RESET, sfr_rdata_out);
    chk("reset_levels", 8'h00, {1'b0, lv});
  endtask
  // Walk a single one across each level bit, bit 7 kept at one by software
  task automatic t_levels();
    for (int i = 0; i < IPSEL_NSRC; i++) begin
      byte_wr(8'hb8, 8'h80 | (8'h01 << i));
      chk("reg", 8'h80 | (8'h01 << i), sfr_rdata_out);
      chk("levels", 8'h01 << i, {1'b0, lv});
    end
    byte_wr(8'hb7, 8'hff);
    chk("other_addr", 8'hc0, sfr_rdata_out);
    byte_wr(8'hb8, 8'h00);
    chk("bit7_ro", 8'h80, sfr_rdata_out);
  endtask
  task automatic t_bits();
    bit_wr(8'hbd, 1'b1);
    bit_wr(8'hbf, 1'b0);
    bit_wr(8'hbb, 1'b1);
    bit_addr_in = 8'hbd;
    #1 chk("bit_rd", 8'h01, {7'h0, bit_rdata_out});
    chk("bit_reg", 8'ha8, sfr_rdata_out);
    chk("bit_levels", 8'h28, {1'b0, lv});
    bit_wr(8'hbb, 1'b0);
    chk("bit_clear", 8'ha0, sfr_rdata_out);
    bit_wr(8'hc3, 1'b1);
    chk("bit_other", 8'ha0, sfr_rdata_out);
  endtask
  // High level wins, blocks while served, then preempts a low service
  task automatic t_arb();
    byte_wr(8'hb8, 8'h84);
    @(negedge clk_in) pending_in = 7'h06;
    #1 chk("grant_hi", 8'h1a, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
    take = 1;
    @(negedge clk_in) take = 0;
    @(negedge clk_in) chk("blocked", 8'h00, {7'h0, grant_valid_out});
    reti_in = 1; pending_in = 7'h01;
    @(negedge clk_in) reti_in = 0;
    chk("grant_lo", 8'h10, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
    take = 1;
    @(negedge clk_in) take = 0;
    @(negedge clk_in) pending_in = 7'h05;
    #1 chk("preempt", 8'h1a, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
    take = 1;
    @(negedge clk_in) take = 0;
    @(negedge clk_in) pending_in = 7'h01;
    #1 chk("nested", 8'h07, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
    reti_in = 1;
    @(negedge clk_in) reti_in = 0;
    chk("pop_high", 8'h07, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
    @(negedge clk_in) reti_in = 1;
    @(negedge clk_in) reti_in = 0;
    chk("pop_low", 8'h10, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
  endtask
  // Reset in mid-run with a low service active must clear the register and the level stack
  task automatic t_mid_reset();
    take = 1;
    @(negedge clk_in) take = 0;
    @(negedge clk_in) chk("low_busy", 8'h07, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
    reset_n_in = 0;
    #1 chk("rst_reg", IPSEL_PRIO_RESET, sfr_rdata_out);
    chk("rst_levels", 8'h00, {1'b0, lv});
    repeat (2) @(negedge clk_in);
    reset_n_in = 1;
    #1 chk("rst_grant", 8'h10, {3'h0, grant_valid_out, grant_high_out, grant_index_out});
  endtask
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clk_in);
    t_reset();
    reset_n_in = 1;
    t_levels();
    t_bits();
    t_arb();
    t_mid_reset();
    close_out();
  end
endmodule
